// >>> design/odl_serial_load.sv
// Purpose: Serial load control of an eight-channel voltage output converter.
// Assumes: clk at 100 MHz; link pins are asynchronous and are sampled by two flip-flops.
// Notes: Word layout chosen here; see header. Serial clock must stay below the sample rate.
// Functional notes
// - A 16-bit shift register takes one data bit on each falling edge of the serial clock.
// - A falling frame sync powers the link inputs and captures the next 16 falling edges.
// - A frame sync rising before the sixteenth falling edge aborts and drops the partial word.
// - After each completed write the clock and data input buffers stay off until the next frame.
// - While the load input is low each input register is copied to its output register.
// - Each group of four channels selects a buffered, unbuffered or supply reference.
`include "odl_cfg.svh"

module odl_serial_load (
    input wire logic clk, // System clock, 100 MHz.
    input wire logic sys_rst, // Asynchronous reset, active high.
    input wire logic serialClk, // Link serial clock pin.
    input wire logic serialData, // Link serial data pin.
    input wire logic frameSync_n, // Link frame sync pin, active low.
    input wire logic loadOutputs_n, // Load pin, active low.
    output logic linkBufferOn, // Serial clock and data input buffers powered.
    output logic [`ODL_CHANNELS*12-1:0] outputCodes, // Output registers, channel 0 lowest.
    output odl_pkg::odl_ref_mode_t refModeLow, // Reference mode of channels 0 to 3.
    output odl_pkg::odl_ref_mode_t refModeHigh, // Reference mode of channels 4 to 7.
    output logic frameAbort, // One-cycle pulse on a dropped frame.
    output logic wordDone // One-cycle pulse when a word is applied.
);
    // ======================================================================
    // Pin synchronisers
    // ======================================================================
    // An edge on a pin is seen about three clocks late. The serial clock must
    // keep each level for several sample clocks, so this sampler follows a link
    // well below the 30 MHz ceiling, not one run at it.
    logic [1:0] sclkSync;
    logic [1:0] dinSync;
    logic [1:0] syncSync;
    logic [1:0] loadSync;
    logic sclkPrev;
    logic syncPrev;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sclkSync <= 2'h3;
            dinSync <= 2'h0;
            syncSync <= 2'h3;
            loadSync <= 2'h3;
            sclkPrev <= 1'b1;
            syncPrev <= 1'b1;
        end else begin
            sclkSync <= {sclkSync[0], serialClk};
            dinSync <= {dinSync[0], serialData};
            syncSync <= {syncSync[0], frameSync_n};
            loadSync <= {loadSync[0], loadOutputs_n};
            sclkPrev <= sclkSync[1];
            syncPrev <= syncSync[1];
        end
    end

    wire logic sclkFall = sclkPrev && !sclkSync[1];
    wire logic syncFall = syncPrev && !syncSync[1];
    wire logic syncRise = !syncPrev && syncSync[1];
    wire logic loadActive = !loadSync[1];

    // ======================================================================
    // Frame state machine
    // ======================================================================
    odl_pkg::odl_frame_state_t state;
    odl_pkg::odl_frame_state_t next_state;
    logic [`ODL_WORD_BITS-1:0] shiftReg;
    logic [`ODL_BIT_CNT_W-1:0] bitCount;

    wire logic shiftBit = (state == odl_pkg::ODL_SHIFT) && sclkFall && !syncRise;
    wire logic lastBit = shiftBit && (bitCount == 5'(`ODL_WORD_BITS - 1));
    wire logic abortNow = (state == odl_pkg::ODL_SHIFT) && syncRise;
    wire logic [`ODL_WORD_BITS-1:0] nextShift = {shiftReg[`ODL_WORD_BITS-2:0], dinSync[1]};

    always_comb begin
        next_state = state;
        unique case (state)
            odl_pkg::ODL_IDLE: begin
                if (syncFall) begin
                    next_state = odl_pkg::ODL_SHIFT;
                end
            end
            odl_pkg::ODL_SHIFT: begin
                if (abortNow) begin
                    next_state = odl_pkg::ODL_IDLE;
                end else if (lastBit) begin
                    next_state = odl_pkg::ODL_WAIT_END;
                end
            end
            odl_pkg::ODL_WAIT_END: begin
                // Edges after the sixteenth are ignored until the frame sync rises.
                if (syncRise) begin
                    next_state = odl_pkg::ODL_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= odl_pkg::ODL_IDLE;
            shiftReg <= '0;
            bitCount <= '0;
        end else begin
            state <= next_state;
            if (syncFall && state == odl_pkg::ODL_IDLE) begin
                bitCount <= '0;
            end else if (shiftBit) begin
                shiftReg <= nextShift;
                bitCount <= bitCount + 5'h01;
            end
        end
    end

    // ======================================================================
    // Link buffer power and abort report
    // ======================================================================
    // The buffers follow the next state, so they are already off in the cycle
    // after the sixteenth edge; any later edge of the frame meets no buffer.
    wire logic bufferPowered = (next_state == odl_pkg::ODL_SHIFT);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            linkBufferOn <= 1'b0;
            frameAbort <= 1'b0;
        end else begin
            linkBufferOn <= bufferPowered;
            frameAbort <= abortNow;
        end
    end

    // ======================================================================
    // Word buffer
    // ======================================================================
    logic bufOutValid;
    logic [`ODL_WORD_BITS-1:0] bufOutWord;

    // A word completes only on the sixteenth edge; a full buffer drops it
    // rather than stall the link, which cannot be paused.
    // Decoded words are applied in the cycle they appear, so the buffer drains.
    odl_word_buffer wordBuffer (
        .clk(clk),
        .sys_rst(sys_rst),
        .inValid(lastBit),
        .inReady(),
        .inWord(nextShift),
        .outValid(bufOutValid),
        .outReady(1'b1),
        .outWord(bufOutWord)
    );

    // ======================================================================
    // Word decode
    // ======================================================================
    // Words with both control bits set are accepted and ignored.
    wire logic isControl = bufOutWord[`ODL_CTL_FLAG_POS];
    wire logic isRefCtl = isControl && !bufOutWord[`ODL_CTL_KIND_POS];
    wire logic [2:0] chanSel = bufOutWord[`ODL_ADDR_MSB:`ODL_ADDR_LSB];
    wire logic [11:0] chanCode = bufOutWord[`ODL_DATA_MSB:`ODL_DATA_LSB];

    // ======================================================================
    // Input and output registers
    // ======================================================================
    // The load pin acts as a level: held low, each output follows its write in
    // the same cycle as the input register.
    logic [11:0] inputReg [`ODL_CHANNELS];

    genvar ch;
    generate
        for (ch = 0; ch < `ODL_CHANNELS; ch++) begin : gChan
            wire logic hit = bufOutValid && !isControl && (chanSel == 3'(ch));
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    inputReg[ch] <= `ODL_CODE_RESET;
                    outputCodes[ch*12 +: 12] <= `ODL_CODE_RESET;
                end else begin
                    if (hit) begin
                        inputReg[ch] <= chanCode;
                    end
                    if (loadActive) begin
                        outputCodes[ch*12 +: 12] <= hit ? chanCode : inputReg[ch];
                    end
                end
            end
        end
    endgenerate

    // ======================================================================
    // Reference selection
    // ======================================================================
    // Supply selection outranks buffering: the buffer bit of the word is ignored then.
    localparam odl_pkg::odl_ref_mode_t refReset = `ODL_VDD_RESET ? odl_pkg::ODL_REF_SUPPLY
        : (`ODL_BUF_RESET ? odl_pkg::ODL_REF_BUFFERED : odl_pkg::ODL_REF_UNBUFFERED);
    wire logic takeRef = bufOutValid && isRefCtl;
    odl_pkg::odl_ref_mode_t next_refModeLow;
    odl_pkg::odl_ref_mode_t next_refModeHigh;

    assign next_refModeLow = bufOutWord[`ODL_VDD_LOW_POS] ? odl_pkg::ODL_REF_SUPPLY
        : (bufOutWord[`ODL_BUF_LOW_POS] ? odl_pkg::ODL_REF_BUFFERED
        : odl_pkg::ODL_REF_UNBUFFERED);
    assign next_refModeHigh = bufOutWord[`ODL_VDD_HIGH_POS] ? odl_pkg::ODL_REF_SUPPLY
        : (bufOutWord[`ODL_BUF_HIGH_POS] ? odl_pkg::ODL_REF_BUFFERED
        : odl_pkg::ODL_REF_UNBUFFERED);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            refModeLow <= refReset;
            refModeHigh <= refReset;
            wordDone <= 1'b0;
        end else begin
            wordDone <= bufOutValid;
            if (takeRef) begin
                refModeLow <= next_refModeLow;
                refModeHigh <= next_refModeHigh;
            end
        end
    end
endmodule // odl_serial_load

// >>> design/odl_cfg.svh
// Purpose: Constants of the octal converter serial load front end.
// Assumes: Included by its bare name by the design files.
// Notes: Word layout is not fixed by the device; field positions below are chosen.
`ifndef ODL_CFG_SVH
`define ODL_CFG_SVH

// ==========================================================================
// Frame and word
// ==========================================================================
`define ODL_WORD_BITS 16
`define ODL_CHANNELS 8
`define ODL_BIT_CNT_W 5
`define ODL_CTL_FLAG_POS 15
`define ODL_ADDR_MSB 14
`define ODL_ADDR_LSB 12
`define ODL_DATA_MSB 11
`define ODL_DATA_LSB 0
`define ODL_CTL_KIND_POS 14
`define ODL_BUF_LOW_POS 2
`define ODL_BUF_HIGH_POS 3
`define ODL_VDD_LOW_POS 4
`define ODL_VDD_HIGH_POS 5

// ==========================================================================
// Reset values
// ==========================================================================
`define ODL_CODE_RESET 12'h000
`define ODL_BUF_RESET 1'b0
`define ODL_VDD_RESET 1'b0

`endif

// >>> design/odl_pkg.sv
// Purpose: Types shared by the serial load front end.
// Assumes: Nothing beyond the configuration header.
// Notes: Holds types only; numbers live in the header.
package odl_pkg;

    // ======================================================================
    // Types
    // ======================================================================
    typedef enum logic [1:0] {
        ODL_REF_UNBUFFERED,
        ODL_REF_BUFFERED,
        ODL_REF_SUPPLY
    } odl_ref_mode_t;

    typedef enum logic [1:0] {
        ODL_IDLE,
        ODL_SHIFT,
        ODL_WAIT_END
    } odl_frame_state_t;

endpackage

// >>> design/odl_word_buffer.sv
// Purpose: Two-entry valid/ready buffer for completed serial words.
// Assumes: Single clock domain, clk at 100 MHz.
// Notes: Full and empty are exact; the writer sees inReady low when both entries hold.
`include "odl_cfg.svh"

module odl_word_buffer (
    input wire logic clk, // System clock.
    input wire logic sys_rst, // Asynchronous reset, active high.
    input wire logic inValid, // Word offered.
    output logic inReady, // Space available.
    input wire logic [`ODL_WORD_BITS-1:0] inWord, // Offered word.
    output logic outValid, // Word available.
    input wire logic outReady, // Consumer takes word.
    output logic [`ODL_WORD_BITS-1:0] outWord // Oldest word.
);
    logic [`ODL_WORD_BITS-1:0] slot [2];
    logic rdPtr;
    logic wrPtr;
    logic [1:0] count;
    wire logic doWrite = inValid && inReady;
    wire logic doRead = outValid && outReady;

    assign inReady = (count != 2'h2);
    assign outValid = (count != 2'h0);
    assign outWord = slot[rdPtr];

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdPtr <= 1'b0;
            wrPtr <= 1'b0;
            count <= 2'h0;
        end else begin
            if (doWrite) begin
                wrPtr <= ~wrPtr;
            end
            if (doRead) begin
                rdPtr <= ~rdPtr;
            end
            count <= count + {1'b0, doWrite} - {1'b0, doRead};
        end
    end

    always_ff @(posedge clk) begin
        if (doWrite) begin
            slot[wrPtr] <= inWord;
        end
    end
endmodule // odl_word_buffer

// >>> sim/odl_serial_load_sva.sv
// Purpose: Port assertions for the serial load front end.
// Assumes: One clock domain; sys_rst asynchronous, active high.
// Notes: Bound into every instance of the top module.
`include "odl_cfg.svh"
module odl_serial_load_chk (
    input wire logic clk, // Clock.
    input wire logic sys_rst, // Reset.
    input wire logic serialClk, // Link clock.
    input wire logic serialData, // Link data.
    input wire logic frameSync_n, // Frame sync.
    input wire logic loadOutputs_n, // Load pin.
    input wire logic linkBufferOn, // Buffers powered.
    input wire logic [`ODL_CHANNELS*12-1:0] outputCodes, // Output registers.
    input wire odl_pkg::odl_ref_mode_t refModeLow, // Low quad reference.
    input wire odl_pkg::odl_ref_mode_t refModeHigh, // High quad reference.
    input wire logic frameAbort, // Abort pulse.
    input wire logic wordDone // Done pulse.
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==================================================================
    // Checks
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence syncHeld;
        $fell(frameSync_n) ##1 !frameSync_n [*5];
    endsequence
    chk_start_powers: assert property (syncHeld |-> linkBufferOn)
        else $error("link buffers off in frame");
    chk_idle_off: assert property (frameSync_n [*6] |-> !linkBufferOn)
        else $error("link buffers on between frames");
    chk_done_off: assert property (wordDone |-> !linkBufferOn)
        else $error("link buffers on after word");
    chk_done_pulse: assert property (wordDone |=> !wordDone && !frameAbort)
        else $error("done pulse too long");
    chk_abort_keeps: assert property (frameAbort |-> $stable(outputCodes) [*3])
        else $error("aborted frame changed outputs");
    chk_abort_pulse: assert property (frameAbort |=> !frameAbort && !wordDone)
        else $error("abort pulse too long");
    chk_load_hold: assert property (loadOutputs_n [*6] |-> $stable(outputCodes))
        else $error("outputs moved with load high");
    chk_ref_legal: assert property (refModeLow != 2'h3 && refModeHigh != 2'h3)
        else $error("illegal reference mode");
    chk_ref_quiet: assert property ($changed({refModeHigh, refModeLow}) |-> !linkBufferOn)
        else $error("reference moved during a frame");
    chk_ref_update: assert property ($changed({refModeHigh, refModeLow}) |-> ##[0:2] wordDone)
        else $error("reference moved without a word");
endmodule // odl_serial_load_chk
bind odl_serial_load odl_serial_load_chk chk (.clk, .sys_rst, .serialClk, .serialData,
    .frameSync_n, .loadOutputs_n, .linkBufferOn, .outputCodes, .refModeLow, .refModeHigh,
    .frameAbort, .wordDone);

// >>> sim/odl_link_master.sv
// Purpose: Controller model that sends one frame on the serial link.
// Assumes: word and nFalls held by the caller while busy.
// Notes: Clock idles high; data shows the inverse of its last bit between frames.
module odl_link_master (
    input wire logic clk, // Clock.
    input wire logic sys_rst, // Reset.
    input wire logic start, // Begin a frame.
    input wire logic [15:0] word, // Word, MSB first.
    input wire logic [4:0] nFalls, // Falling edges before sync rises.
    output logic busy, // Frame in progress.
    output logic serialClk, // Link clock.
    output logic serialData, // Link data.
    output logic frameSync_n // Frame sync.
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==================================================================
    // Frame timing
    logic [9:0] t;
    logic lastBit;
    wire [9:0] span = {1'b0, nFalls, 4'h0};
    wire inFrame = busy && (t < span);
    wire curBit = word[4'hf - t[7:4]];
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            busy <= 1'b0;
            t <= 10'h000;
            lastBit <= 1'b0;
        end else begin
            busy <= busy ? (t != span + 10'h00c) : start;
            t <= busy ? t + 10'h001 : 10'h000;
            if (inFrame) lastBit <= curBit;
        end
    end
    // A 160 ns bit keeps the link well below its ceiling and the sampler.
    assign serialClk = !(inFrame && t[3]);
    assign serialData = inFrame ? curBit : !lastBit;
    assign frameSync_n = !(busy && t < span + 10'h004);
endmodule // odl_link_master

// >>> sim/odl_serial_load_bench.sv
// Purpose: Self-checking bench of the serial load front end.
// Assumes: 100 MHz clock; link frames come from the controller model.
// Notes: Outputs are sampled on falling clock edges to stay clear of updates.
module odl_serial_load_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic loadOutputs_n = 1'b1;
    logic start = 1'b0;
    logic [15:0] word = 16'h0000;
    logic [4:0] nFalls = 5'h10;
    logic busy, serialClk, serialData, frameSync_n, linkBufferOn, frameAbort, wordDone;
    logic [95:0] outputCodes;
    logic [95:0] expCodes = 96'h0;
    odl_pkg::odl_ref_mode_t refModeLow, refModeHigh;
    logic [15:0] refWords [6] = '{16'h8004, 16'h8008, 16'h8014, 16'h8020, 16'hc030, 16'h8000};
    logic [3:0] refExp [6] = '{4'h1, 4'h4, 4'h2, 4'h8, 4'h8, 4'h0};
    int err_count = 0;
    int samples_checked = 0;
    int dones = 0;
    int aborts = 0;
    initial forever #5 clk = ~clk;
    always @(negedge clk) begin
        if (wordDone === 1'b1) dones++;
        if (frameAbort === 1'b1) aborts++;
    end
    odl_serial_load dut (.clk, .sys_rst, .serialClk, .serialData, .frameSync_n,
        .loadOutputs_n, .linkBufferOn, .outputCodes, .refModeLow, .refModeHigh,
        .frameAbort, .wordDone);
    odl_link_master partner (.clk, .sys_rst, .start, .word, .nFalls, .busy, .serialClk,
        .serialData, .frameSync_n);
    // ==================================================================
    // Shared tasks
    task automatic check(input logic [95:0] seen, input logic [95:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t ns: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic results();
        if (err_count == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic send(input logic [15:0] w, input logic [4:0] n);
        int k;
        @(posedge clk);
        word <= w;
        nFalls <= n;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        @(negedge clk);
        for (k = 0; k < 400 && busy !== 1'b0; k++) @(negedge clk);
        if (k == 400) begin
            err_count++;
            results();
        end
        repeat (4) @(negedge clk);
    endtask
    // ==================================================================
    // Scenarios
    task automatic t_reset();
        check(outputCodes, 96'h0);
        check({refModeHigh, refModeLow}, 4'h0);
        check(linkBufferOn, 1'b0);
    endtask
    task automatic t_tied();
        int d;
        logic [11:0] code;
        @(posedge clk);
        loadOutputs_n <= 1'b0;
        for (int ch = 0; ch < 8; ch++) begin
            d = dones;
            code = 12'hfff ^ (12'h111 * ch[11:0]);
            send({1'b0, ch[2:0], code}, 5'h10);
            expCodes[12*ch +: 12] = code;
            check(outputCodes, expCodes);
            check(dones - d, 1);
            check(linkBufferOn, 1'b0);
        end
    endtask
    task automatic t_pulse();
        @(posedge clk);
        loadOutputs_n <= 1'b1;
        send({4'h3, 12'h5a5}, 5'h10);
        check(outputCodes, expCodes);
        @(posedge clk);
        loadOutputs_n <= 1'b0;
        repeat (4) @(posedge clk);
        loadOutputs_n <= 1'b1;
        repeat (5) @(negedge clk);
        expCodes[36 +: 12] = 12'h5a5;
        check(outputCodes, expCodes);
    endtask
    task automatic t_abort();
        int a;
        @(posedge clk);
        loadOutputs_n <= 1'b0;
        for (int n = 1; n < 16; n += 7) begin
            a = aborts;
            send({4'h1, 12'h123}, n[4:0]);
            check(aborts - a, 1);
            check(outputCodes, expCodes);
        end
        send({4'h1, 12'h321}, 5'h10);
        expCodes[12 +: 12] = 12'h321;
        check(outputCodes, expCodes);
    endtask
    task automatic t_ref();
        for (int i = 0; i < 6; i++) begin
            send(refWords[i], 5'h10);
            check({refModeHigh, refModeLow}, refExp[i]);
        end
        check(outputCodes, expCodes);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(negedge clk);
        t_reset();
        t_tied();
        t_pulse();
        t_abort();
        t_ref();
        results();
    end
endmodule // odl_serial_load_bench
